// ===== shared/monitor_cfg_params.svh
/*
  offsets, field positions, reset values and counts for the monitor
  interrupt-mode, fan-divisor and shared-pin configuration block.
  assumes inclusion by bare name from the package and the design.
*/
// Overview of operation
// RULE1 - A one in bit 5 of the second mask register keeps the over-temperature status off the interrupt output.
// RULE2 - With bit 6 low the hot status is set at every conversion while above the hot limit until below hysteresis.
// RULE3 - With bit 6 high the hot status is set once on rising above hot and once on falling below hysteresis.
// RULE4 - Bit 7 picks the same repeating or one-time behaviour for the over-temperature status bit.
// RULE5 - A status read clears the status bits, and in one-time mode the next conversion need not set them again.
// RULE6 - Bit 0 of the fan divisor register puts the first tach input in level mode when one, counting when zero.
// RULE7 - Bit 1 of the fan divisor register puts the second tach input in level mode when one, counting when zero.
// RULE8 - Bits 3:2 divide the first tach count clock by 1, 2, 4 or 8.
// RULE9 - Bits 5:4 divide the second tach count clock by 1, 2, 4 or 8.
// RULE10 - In level mode bit 2 high makes the tach input active low, bit 2 low makes it active high.
// RULE11 - Bit 6 high with bit 7 low runs the shared pin as the over-temperature shutdown output.
// RULE12 - Bit 7 high runs the shared pin as a reset output.
// RULE13 - Bits 6 and 7 both low disable the shared pin.
// RULE14 - At power-on the fan divisor register upper nibble is 0101 and the lower nibble comes from the voltage id inputs.
// RULE15 - In counting mode each fan reading holds the count of divided clocks over one revolution.
// RULE16 - With bits 6 and 7 both high the reset mode takes precedence on the shared pin.
`ifndef MONITOR_CFG_PARAMS_SVH
`define MONITOR_CFG_PARAMS_SVH
`define MASK2_OFS 8'h04
`define FANDIV_OFS 8'h05
`define MASK2_RST 8'h00
`define FANDIV_RST_HI 4'h5
`define M2_HOT_MASK 0
`define M2_OST_MASK 5
`define M2_HOT_MODE 6
`define M2_OST_MODE 7
`define FD_MODE_ONE 0
`define FD_MODE_TWO 1
`define FD_POL 2
`define FD_DIV_ONE 2
`define FD_DIV_TWO 4
`define FD_OS_EN 6
`define FD_RST_EN 7
`define FAN_COUNT_MAX 8'hFF
`define VID_LOAD_AT 2'h2
`endif

// ===== shared/monitor_cfg_pkg.sv
/*
  types for the monitor configuration block.
  assumes the params header is on the include path.
*/
package monitor_cfg_pkg;
  `include "monitor_cfg_params.svh"
  typedef enum logic [1:0] {PIN_OFF, PIN_OS, PIN_RST} pin_mode_t;
  typedef struct packed {
    logic [7:0] mask2_reg;
    logic [7:0] fandiv_reg;
    logic [1:0] vid_wait_reg;
    logic [3:0] vid_s1_reg;
    logic [3:0] vid_s2_reg;
    logic hot_stat_reg;
    logic ost_stat_reg;
    logic hot_above_reg;
    logic ost_above_reg;
    logic [1:0] tach_s1_reg;
    logic [1:0] tach_s2_reg;
    logic [1:0] tach_s3_reg;
    logic [2:0] presc_reg;
    logic [1:0][7:0] cnt_reg;
    logic [1:0][7:0] reading_reg;
    logic [1:0] lvl_alarm_reg;
    pin_mode_t pin_mode_reg;
    logic pin_oe_reg;
    logic irq_reg;
    logic [7:0] rd_data_reg;
  } cfg_state_t;
endpackage

// ===== rtl/monitor_irq_mode_fan_config.sv
/*
  mask/mode bits of the second interrupt mask register, the fan divisor
  and shared-pin register, the two status bits they steer, the tach
  counters and the shared pin drive.
  assumes the serial bus engine, the comparators and the reset source
  all run on CLK_SYS; tach and voltage id pins are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
`include "monitor_cfg_params.svh"
module monitor_irq_mode_fan_config
  import monitor_cfg_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CE,
  // register port from the serial bus engine
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  output logic [7:0] RD_DATA,
  // conversion results and status read
  input wire logic CONV_DONE,
  input wire logic HOT_ABOVE,
  input wire logic HOT_BELOW_HYST,
  input wire logic OST_ABOVE,
  input wire logic OST_BELOW_HYST,
  input wire logic STATUS_RD,
  output logic HOT_STATUS,
  output logic OST_STATUS,
  output logic IRQ_OUT,
  // tach and voltage id pins
  input wire logic TACH_INPUT_ONE,
  input wire logic TACH_INPUT_TWO,
  input wire logic [3:0] VOLTAGE_ID_INPUTS,
  output logic [7:0] FAN_READING_ONE,
  output logic [7:0] FAN_READING_TWO,
  output logic [1:0] FAN_LEVEL_ALARM,
  // shared reset / over-temperature pin, open drain active low
  input wire logic RESET_REQ,
  input wire logic OVERTEMP_SHUTDOWN_OUTPUT,
  output logic SHARED_PIN_O,
  output logic SHARED_PIN_OE,
  output logic [1:0] PIN_MODE
);
  logic rst_s1, rst_n;
  cfg_state_t st_reg, st_next;
  logic [1:0] hot_upd, ost_upd;
  logic [1:0] tach_rise, tick;
  logic [1:0] fan_level;
  logic [1:0][1:0] div_code;
  logic [2:0] div_mask;

  // one status source: returns {set, new above-state}
  function automatic logic [1:0] status_step(input logic one_time, input logic above_st,
                                             input logic conv, input logic above, input logic below);
    logic nst;
    logic set;
    nst = above_st;
    set = 1'b0;
    if (conv) begin
      nst = above ? 1'b1 : (below ? 1'b0 : above_st);
      if (one_time) begin
        set = (~above_st & above) | (above_st & below); // RULE3
      end else begin
        set = nst; // RULE2
      end
    end
    return {set, nst};
  endfunction

  // reset release through two flops
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    // synchronisers; first stage only feeds the second
    st_next.vid_s1_reg = VOLTAGE_ID_INPUTS;
    st_next.vid_s2_reg = st_reg.vid_s1_reg;
    st_next.tach_s1_reg = {TACH_INPUT_TWO, TACH_INPUT_ONE};
    st_next.tach_s2_reg = st_reg.tach_s1_reg;
    st_next.tach_s3_reg = st_reg.tach_s2_reg;
    // register writes
    if (WR_EN && ADDR == `MASK2_OFS) begin
      st_next.mask2_reg = WR_DATA;
    end
    if (WR_EN && ADDR == `FANDIV_OFS) begin
      st_next.fandiv_reg = WR_DATA;
    end
    // strap: voltage id caught once the synchroniser has filled after release
    if (st_reg.vid_wait_reg != 2'h3) begin
      st_next.vid_wait_reg = st_reg.vid_wait_reg + 2'h1;
    end
    if (st_reg.vid_wait_reg == `VID_LOAD_AT && !(WR_EN && ADDR == `FANDIV_OFS)) begin
      st_next.fandiv_reg[3:0] = st_reg.vid_s2_reg; // RULE14
    end
    // status bits: a set in the read cycle wins over the clear
    hot_upd = status_step(st_reg.mask2_reg[`M2_HOT_MODE], st_reg.hot_above_reg, CONV_DONE,
                          HOT_ABOVE, HOT_BELOW_HYST);
    ost_upd = status_step(st_reg.mask2_reg[`M2_OST_MODE], st_reg.ost_above_reg, CONV_DONE,
                          OST_ABOVE, OST_BELOW_HYST); // RULE4
    st_next.hot_above_reg = hot_upd[0];
    st_next.ost_above_reg = ost_upd[0];
    st_next.hot_stat_reg = hot_upd[1] | (st_reg.hot_stat_reg & ~STATUS_RD); // RULE5
    st_next.ost_stat_reg = ost_upd[1] | (st_reg.ost_stat_reg & ~STATUS_RD); // RULE5
    // interrupt output lags the status bits by one cycle
    st_next.irq_reg = (st_reg.hot_stat_reg & ~st_reg.mask2_reg[`M2_HOT_MASK]) |
                      (st_reg.ost_stat_reg & ~st_reg.mask2_reg[`M2_OST_MASK]); // RULE1
    // tach measurement; the prescaler runs free so a reading can gain or lose one with the fan phase
    st_next.presc_reg = st_reg.presc_reg + 3'h1;
    div_code[0] = st_reg.fandiv_reg[`FD_DIV_ONE +: 2]; // RULE8
    div_code[1] = st_reg.fandiv_reg[`FD_DIV_TWO +: 2]; // RULE9
    fan_level[0] = st_reg.fandiv_reg[`FD_MODE_ONE]; // RULE6
    fan_level[1] = st_reg.fandiv_reg[`FD_MODE_TWO]; // RULE7
    div_mask = 3'h0;
    for (int i = 0; i < 2; i++) begin
      div_mask = 3'((4'h1 << div_code[i]) - 4'h1);
      tick[i] = (st_reg.presc_reg & div_mask) == 3'h0;
      tach_rise[i] = st_reg.tach_s2_reg[i] & ~st_reg.tach_s3_reg[i];
      if (fan_level[i]) begin
        // one polarity bit serves both inputs
        st_next.lvl_alarm_reg[i] = st_reg.fandiv_reg[`FD_POL] ? ~st_reg.tach_s2_reg[i]
                                                               : st_reg.tach_s2_reg[i]; // RULE10
        st_next.cnt_reg[i] = 8'h00;
      end else begin
        st_next.lvl_alarm_reg[i] = 1'b0;
        if (tach_rise[i]) begin
          st_next.reading_reg[i] = st_reg.cnt_reg[i]; // RULE15
          st_next.cnt_reg[i] = 8'h00;
        end else if (tick[i] && st_reg.cnt_reg[i] != `FAN_COUNT_MAX) begin
          st_next.cnt_reg[i] = st_reg.cnt_reg[i] + 8'h01; // saturates for a stopped fan
        end
      end
    end
    // shared pin mode, reset wins when both enables are set
    if (st_reg.fandiv_reg[`FD_RST_EN]) begin
      st_next.pin_mode_reg = PIN_RST; // RULE12 RULE16
    end else if (st_reg.fandiv_reg[`FD_OS_EN]) begin
      st_next.pin_mode_reg = PIN_OS; // RULE11
    end else begin
      st_next.pin_mode_reg = PIN_OFF; // RULE13
    end
    unique case (st_reg.pin_mode_reg)
      PIN_RST: st_next.pin_oe_reg = RESET_REQ;
      PIN_OS: st_next.pin_oe_reg = OVERTEMP_SHUTDOWN_OUTPUT;
      PIN_OFF: st_next.pin_oe_reg = 1'b0;
      default: st_next.pin_oe_reg = 1'b0;
    endcase
    // read data, unmapped offsets read zero
    if (RD_EN) begin
      st_next.rd_data_reg = (ADDR == `MASK2_OFS) ? st_reg.mask2_reg :
                            (ADDR == `FANDIV_OFS) ? st_reg.fandiv_reg : 8'h00;
    end
  end

  // state register, frozen while CE is low
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.mask2_reg <= `MASK2_RST;
      st_reg.fandiv_reg <= {`FANDIV_RST_HI, 4'h0}; // RULE14
      st_reg.pin_mode_reg <= PIN_RST;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops, except SHARED_PIN_O which is tied low
  assign RD_DATA = st_reg.rd_data_reg;
  assign HOT_STATUS = st_reg.hot_stat_reg;
  assign OST_STATUS = st_reg.ost_stat_reg;
  assign IRQ_OUT = st_reg.irq_reg;
  assign FAN_READING_ONE = st_reg.reading_reg[0];
  assign FAN_READING_TWO = st_reg.reading_reg[1];
  assign FAN_LEVEL_ALARM = st_reg.lvl_alarm_reg;
  assign SHARED_PIN_O = 1'b0;
  assign SHARED_PIN_OE = st_reg.pin_oe_reg;
  assign PIN_MODE = st_reg.pin_mode_reg;

  // checks
  property p_ost_mask;
    @(posedge CLK_SYS) disable iff (!rst_n)
      CE && st_reg.mask2_reg[`M2_OST_MASK] && !st_reg.hot_stat_reg |=> !IRQ_OUT;
  endproperty
  a_ost_mask: assert property (p_ost_mask) else $error("masked overtemp reached irq"); // RULE1
  property p_hot_repeat;
    @(posedge CLK_SYS) disable iff (!rst_n)
      CE && CONV_DONE && !st_reg.mask2_reg[`M2_HOT_MODE] && HOT_ABOVE |=> HOT_STATUS;
  endproperty
  a_hot_repeat: assert property (p_hot_repeat) else $error("repeat mode missed a hot set"); // RULE2
  property p_hot_once;
    @(posedge CLK_SYS) disable iff (!rst_n)
      CE && CONV_DONE && st_reg.mask2_reg[`M2_HOT_MODE] && st_reg.hot_above_reg && !HOT_BELOW_HYST
      && STATUS_RD |=> !HOT_STATUS;
  endproperty
  a_hot_once: assert property (p_hot_once) else $error("one-time mode set hot again"); // RULE3
  property p_ost_once;
    @(posedge CLK_SYS) disable iff (!rst_n)
      CE && CONV_DONE && st_reg.mask2_reg[`M2_OST_MODE] && !st_reg.ost_above_reg && OST_ABOVE
      |=> OST_STATUS && st_reg.ost_above_reg;
  endproperty
  a_ost_once: assert property (p_ost_once) else $error("one-time overtemp crossing missed"); // RULE4
  property p_clear;
    @(posedge CLK_SYS) disable iff (!rst_n)
      CE && STATUS_RD && !CONV_DONE |=> !HOT_STATUS && !OST_STATUS;
  endproperty
  a_clear: assert property (p_clear) else $error("status read did not clear"); // RULE5
  property p_level_alarm;
    @(posedge CLK_SYS) disable iff (!rst_n)
      CE && st_reg.fandiv_reg[`FD_MODE_ONE] && st_reg.fandiv_reg[`FD_POL] |=>
      FAN_LEVEL_ALARM[0] == !$past(st_reg.tach_s2_reg[0]);
  endproperty
  a_level_alarm: assert property (p_level_alarm) else $error("level alarm polarity wrong"); // RULE6 RULE10
  property p_count_mode;
    @(posedge CLK_SYS) disable iff (!rst_n)
      CE && !st_reg.fandiv_reg[`FD_MODE_TWO] |=> !FAN_LEVEL_ALARM[1];
  endproperty
  a_count_mode: assert property (p_count_mode) else $error("count mode raised level alarm"); // RULE7
  property p_div8;
    @(posedge CLK_SYS) disable iff (!rst_n)
      CE && st_reg.fandiv_reg[`FD_DIV_ONE +: 2] == 2'h3 && st_reg.presc_reg != 3'h0 |=>
      st_reg.cnt_reg[0] == $past(st_reg.cnt_reg[0]) || st_reg.cnt_reg[0] == 8'h00;
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight counted off tick"); // RULE8 RULE15
  property p_pin_mode;
    @(posedge CLK_SYS) disable iff (!rst_n)
      CE |=> PIN_MODE == ($past(st_reg.fandiv_reg[`FD_RST_EN]) ? PIN_RST :
                          $past(st_reg.fandiv_reg[`FD_OS_EN]) ? PIN_OS : PIN_OFF);
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("shared pin mode wrong"); // RULE11 RULE12 RULE16
  property p_pin_off;
    @(posedge CLK_SYS) disable iff (!rst_n)
      CE && PIN_MODE == PIN_OFF |=> !SHARED_PIN_OE;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disabled pin driven"); // RULE13
  property p_strap;
    @(posedge CLK_SYS) disable iff (!rst_n)
      CE && st_reg.vid_wait_reg == `VID_LOAD_AT && !WR_EN |=>
      st_reg.fandiv_reg == {`FANDIV_RST_HI, $past(st_reg.vid_s2_reg)};
  endproperty
  a_strap: assert property (p_strap) else $error("voltage id strap not loaded"); // RULE14
endmodule
`default_nettype wire

// ===== dv/fan_tach_model.sv
/*
  fan side model: a square tach wave of programmable half period,
  or a held level for the level-sensitive tests.
  assumes the bench changes its controls just after a clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module fan_tach_model (
  // clock
  input wire logic clk,
  // controls
  input wire logic [7:0] half_cycles,
  input wire logic lvl_sel,
  input wire logic lvl,
  // pin
  output logic tach
);
  logic osc = 1'b0;
  int cnt = 0;
  // free running wave, not locked to conversions, as a real fan would be
  always @(posedge clk) begin
    if (cnt + 1 >= half_cycles) begin
      cnt <= 0;
      osc <= ~osc;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign tach = lvl_sel ? lvl : osc;
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
/*
  self-checking bench for the monitor configuration block.
  assumes the package, params header and fan model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import monitor_cfg_pkg::*;
  logic clk = 0, rst_b = 0, wr_en = 0, rd_en = 0, conv = 0, st_rd = 0, above = 0, below = 0;
  logic rst_req = 0, os_req = 0, lvl_sel = 1, lvl = 0, tach, hot_s, ost_s, irq, pin_o, pin_oe;
  logic [7:0] addr = 0, wdata = 0, rdata, rd1, rd2, half = 8'h10, mv;
  logic [1:0] alarm, pin_mode;
  logic [3:0] voltage_id_inputs = 4'hA;
  int mismatches = 0, compares = 0, cycles = 0;
  localparam logic [8:0] EXP_REP = 9'h015;
  localparam logic [8:0] EXP_ONE = 9'h041;

  // voltage id straps change only while reset is held, enable always on
  monitor_irq_mode_fan_config dut (.CLK_SYS(clk), .RST_B(rst_b), .CE(1'b1), .WR_EN(wr_en), .RD_EN(rd_en),
    .ADDR(addr), .WR_DATA(wdata), .RD_DATA(rdata), .CONV_DONE(conv), .HOT_ABOVE(above),
    .HOT_BELOW_HYST(below), .OST_ABOVE(above), .OST_BELOW_HYST(below), .STATUS_RD(st_rd),
    .HOT_STATUS(hot_s), .OST_STATUS(ost_s), .IRQ_OUT(irq), .TACH_INPUT_ONE(tach), .TACH_INPUT_TWO(tach),
    .VOLTAGE_ID_INPUTS(voltage_id_inputs), .FAN_READING_ONE(rd1), .FAN_READING_TWO(rd2), .FAN_LEVEL_ALARM(alarm),
    .RESET_REQ(rst_req), .OVERTEMP_SHUTDOWN_OUTPUT(os_req), .SHARED_PIN_O(pin_o),
    .SHARED_PIN_OE(pin_oe), .PIN_MODE(pin_mode));
  fan_tach_model fan (.clk(clk), .half_cycles(half), .lvl_sel(lvl_sel), .lvl(lvl), .tach(tach));

  always #12.5 clk = ~clk;

  task automatic report_and_stop();
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // a hang is cut short well beyond the fewer than 800 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // tach counts may lose or gain one against the free prescaler phase
  task automatic chk_near(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if ((g + 8'h01 >= e && g <= e + 8'h01) !== 1'b1) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one strobe cycle, then a quiet edge so strobes never meet back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(nm, e, rdata);
    @(posedge clk);
  endtask

  // conversion and/or status read; leaves time for status and then irq to land
  task automatic step(input logic a, input logic b, input logic cv, input logic rs);
    above <= a;
    below <= b;
    conv <= cv;
    st_rd <= rs;
    @(posedge clk);
    conv <= 1'b0;
    st_rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    rd(8'h05, 8'h5A, "fan divisor reset");
    rd(8'h04, 8'h00, "mask two reset");
    chk("pin mode reset", 8'(PIN_OS), 8'(pin_mode));
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'hFF, "mask two rw");
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00, "unmapped");
    $display("register test done");
    // hot channel, then over-temperature channel, each in both modes
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 2; m++) begin
        mv = s ? {m[0], !m[0], 6'h01} : {!m[0], m[0], 6'h20};
        wr(8'h04, mv);
        step(1'b0, 1'b1, 1'b1, 1'b0);
        @(posedge clk);
        step(1'b0, 1'b0, 1'b0, 1'b1);
        @(posedge clk);
        for (int i = 0; i < 9; i++) begin
          // at i == 2 a status read meets the conversion, so the set must win in repeat mode
          step(i == 0 || i == 2, i == 6 || i == 8, i % 2 == 0, i % 2 == 1 || i == 2);
          chk("status", 8'(m ? EXP_ONE[i] : EXP_REP[i]), 8'(s ? ost_s : hot_s));
          chk("irq", 8'(m ? EXP_ONE[i] : EXP_REP[i]), 8'(irq));
          @(posedge clk);
        end
      end
    end
    $display("interrupt mode test done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h05, {k[1], k[0], 6'h00});
      for (int j = 0; j < 2; j++) begin
        os_req <= j[0];
        rst_req <= !j[0];
        repeat (4) @(posedge clk);
        chk("pin mode", 8'(k[1] ? PIN_RST : (k[0] ? PIN_OS : PIN_OFF)), 8'(pin_mode));
        chk("pin enable", 8'(k[1] ? !j[0] : (k[0] & j[0])), 8'(pin_oe));
        chk("pin level", 8'h00, 8'(pin_o));
      end
    end
    $display("shared pin test done");
    for (int md = 1; md < 4; md++) begin
      for (int p = 0; p < 2; p++) begin
        wr(8'h05, 8'(md | (p << 2)));
        for (int v = 0; v < 2; v++) begin
          lvl <= v[0];
          repeat (5) @(posedge clk);
          chk("level alarm", 8'(md[1:0] & {2{p[0] ^ v[0]}}), 8'(alarm));
        end
      end
    end
    $display("level mode test done");
    lvl_sel <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      wr(8'h05, {2'b00, d[1:0], d[1:0], 2'b00});
      repeat (120) @(posedge clk);
      chk_near("fan one count", 8'(32 >> d), rd1);
      chk_near("fan two count", 8'(32 >> d), rd2);
    end
    $display("fan count test done");
    // second reset with other straps: the low nibble must follow the pins, not a fixed value
    voltage_id_inputs <= 4'h3;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    rd(8'h05, 8'h53, "fan divisor strap");
    chk("pin mode strap", 8'(PIN_OS), 8'(pin_mode));
    $display("reset strap test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
